// [include/power_mode_defs.svh]
// Purpose: Constants for the power-mode controller
// Assumes: Single 40 MHz clock, synchronous active-high reset
// Notes: Timing counts derived from times in ns
// Functional notes
// - Three low-power states plus running
// - Sleep gates only the core clock
// - Any interrupt or event ends sleep
// - Deep-sleep stops core clocks, oscillators, PLLs
// - Deep-sleep retains SRAM and registers
// - Deep-sleep regulator mode from select bit
// - Interrupt controller wake sources end deep-sleep
// - Deep-sleep exit selects fast RC oscillator
// - Standby powers off core, regulator, oscillators
// - Standby loses core state, returns reset
// - Standby exits only on seven sources
`ifndef POWER_MODE_DEFS_SVH
`define POWER_MODE_DEFS_SVH

`define CLK_PERIOD_NS        25
`define OSC_SETTLE_NS        2000
`define OSC_SETTLE_CYC       ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_RESET_NS        1000
`define CORE_RESET_CYC       ((`CORE_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W                8
`define EXT_LINES            16
`define SRC_EXTERNAL_INTERRUPT_CONTROLLER_LINES_LO    0
`define SRC_RTC_ALARM        16
`define SRC_RTC_TAMPER       17
`define SRC_RTC_STAMP        18
`define SRC_RTC_WAKE_TMR     19
`define SRC_LOW_SPEED_CRYSTAL_OSC_STUCK      20
`define SRC_VDET             21
`define SRC_CMP              22
`define SRC_LOW_POWER_TIMER          23
`define SRC_CAN              24
`define SRC_I2C              25
`define SRC_USART            26
`define WAKE_SRC_W           27
`define STBY_SRC_W           5
`define SYSCLK_RC_FAST       2'h0
`define SYSCLK_W             2

`endif

// [include/power_mode_pkg.sv]
// Purpose: Types for the power-mode controller
// Assumes: Included after the defs header
// Notes: One-hot state codes
package power_mode_pkg;
  typedef enum logic [1:0] {
    TGT_SLEEP   = 2'h0,
    TGT_DEEP    = 2'h1,
    TGT_STANDBY = 2'h2
  } target_t;

  typedef enum logic [7:0] {
    ST_RUN        = 8'h01,
    ST_SLEEP      = 8'h02,
    ST_DEEP       = 8'h04,
    ST_DEEP_WAKE  = 8'h08,
    ST_STANDBY    = 8'h10,
    ST_STBY_RESET = 8'h20,
    ST_STBY_WAKE  = 8'h40,
    ST_SPARE      = 8'h80
  } pstate_t;
endpackage : power_mode_pkg

// [design/wake_sync.sv]
// Purpose: Two-flop synchroniser bank for wake inputs
// Assumes: Inputs asynchronous to clk
// Notes: Stage one feeds only stage two
`timescale 1ns/10ps
module wake_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         clkEn,
  input  wire logic         reset,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (clkEn) begin
      meta_d = asyncIn;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule : wake_sync

// [design/power_saving_mode_control.sv]
// Purpose: Sleep, deep-sleep and standby sequencing
// Assumes: CPU requests via wait pulse with target held
// Notes: Wake inputs pass a two-flop synchroniser
`timescale 1ns/10ps
`include "power_mode_defs.svh"
module power_saving_mode_control
  import power_mode_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     clkEn,
  input  wire logic                     reset,
  input  wire logic                     waitReq,
  input  wire logic [1:0]               targetMode,
  input  wire logic                     regulator_low_power_select,
  input  wire logic                     anyIrqOrEvent,
  input  wire logic [`EXT_LINES-1:0]    extLines,
  input  wire logic                     rtcAlarm,
  input  wire logic                     rtcTamper,
  input  wire logic                     rtcStamp,
  input  wire logic                     rtcWakeTimer,
  input  wire logic                     low_speed_crystal_osc_stuck,
  input  wire logic                     low_voltage_detector,
  input  wire logic                     analog_supply_detector,
  input  wire logic                     over_voltage_detector,
  input  wire logic                     under_voltage_detector,
  input  wire logic [7:0]               analog_comparator,
  input  wire logic                     low_power_timer,
  input  wire logic                     canWake,
  input  wire logic                     i2cWake,
  input  wire logic                     usartWake,
  input  wire logic                     external_reset_pin_n,
  input  wire logic                     free_running_watchdog_reset,
  input  wire logic                     wakeup_pin,
  output logic                          coreClkEn,
  output logic                          periphClkEn,
  output logic                          coreDomainClkEn,
  output logic                          internal_rc_osc_fast_en,
  output logic                          high_speed_crystal_osc_en,
  output logic                          pllEn,
  output logic                          internal_regulator_on,
  output logic                          internal_regulator_lp,
  output logic                          retainState,
  output logic                          coreDomainPowered,
  output logic                          coreDomainReset,
  output logic                          sysClkForceRc,
  output logic [`SYSCLK_W-1:0]          sysClkSel,
  output logic                          wakeFromStandby,
  output pstate_t                       powerState
);
  localparam int WIN = `WAKE_SRC_W + 3 + 8;

  logic [WIN-1:0] rawIn;
  logic [WIN-1:0] syncIn;

  assign rawIn = {analog_comparator, external_reset_pin_n, free_running_watchdog_reset, wakeup_pin,
                  usartWake, i2cWake, canWake, low_power_timer, 1'b0,
                  low_voltage_detector | analog_supply_detector | over_voltage_detector | under_voltage_detector,
                  low_speed_crystal_osc_stuck, rtcWakeTimer, rtcStamp, rtcTamper, rtcAlarm, extLines};

  wake_sync #(.W(WIN)) uSync (
    .clk     (clk),
    .clkEn   (clkEn),
    .reset   (reset),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );

  logic [`WAKE_SRC_W-1:0] deepSrc;
  logic                   cmpAny;
  logic                   rstPinN;
  logic                   wdgRst;
  logic                   wkupLvl;
  logic                   wkupPrev_q;
  logic                   wkupPrev_d;
  logic                   deepWake;
  logic                   stbyWake;

  assign cmpAny   = |syncIn[WIN-1 -: 8];
  assign rstPinN  = syncIn[`WAKE_SRC_W+2];
  assign wdgRst   = syncIn[`WAKE_SRC_W+1];
  assign wkupLvl  = syncIn[`WAKE_SRC_W];

  // Comparator outputs fold into one deep-sleep source slot
  function automatic logic [`WAKE_SRC_W-1:0] deep_sources(input logic [`WAKE_SRC_W-1:0] s, input logic c);
    logic [`WAKE_SRC_W-1:0] r;
    r = s;
    r[`SRC_CMP] = c;
    return r;
  endfunction : deep_sources

  assign deepSrc  = deep_sources(syncIn[`WAKE_SRC_W-1:0], cmpAny);
  assign deepWake = |deepSrc;
  // Only the seven standby sources are looked at
  assign stbyWake = !rstPinN || deepSrc[`SRC_RTC_ALARM] || deepSrc[`SRC_RTC_STAMP]
                    || deepSrc[`SRC_RTC_TAMPER] || wdgRst || deepSrc[`SRC_LOW_SPEED_CRYSTAL_OSC_STUCK]
                    || (wkupLvl && !wkupPrev_q);

  pstate_t              state_q;
  pstate_t              state_d;
  logic [`CNT_W-1:0]    cnt_q;
  logic [`CNT_W-1:0]    cnt_d;
  logic                 lpSel_q;
  logic                 lpSel_d;
  logic                 fromStby_q;
  logic                 fromStby_d;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    lpSel_d    = lpSel_q;
    fromStby_d = fromStby_q;
    wkupPrev_d = wkupLvl;
    case (state_q)
      ST_RUN: begin
        if (waitReq) begin
          case (targetMode)
            TGT_SLEEP:   state_d = ST_SLEEP;
            TGT_DEEP: begin
              state_d = ST_DEEP;
              lpSel_d = regulator_low_power_select;
            end
            TGT_STANDBY: state_d = ST_STANDBY;
            default:     state_d = ST_RUN;
          endcase
        end
      end
      ST_SLEEP: begin
        if (anyIrqOrEvent || deepWake) begin
          state_d = ST_RUN;
        end
      end
      ST_DEEP: begin
        if (deepWake) begin
          state_d = ST_DEEP_WAKE;
          cnt_d   = `CNT_W'(`OSC_SETTLE_CYC - 1);
        end
      end
      ST_DEEP_WAKE: begin
        if (cnt_q == '0) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - `CNT_W'(1);
        end
      end
      ST_STANDBY: begin
        if (stbyWake) begin
          state_d    = ST_STBY_WAKE;
          cnt_d      = `CNT_W'(`OSC_SETTLE_CYC - 1);
        end
      end
      ST_STBY_WAKE: begin
        if (cnt_q == '0) begin
          state_d = ST_STBY_RESET;
          cnt_d   = `CNT_W'(`CORE_RESET_CYC - 1);
        end else begin
          cnt_d = cnt_q - `CNT_W'(1);
        end
      end
      ST_STBY_RESET: begin
        if (cnt_q == '0) begin
          state_d    = ST_RUN;
          fromStby_d = 1'b1;
        end else begin
          cnt_d = cnt_q - `CNT_W'(1);
        end
      end
      default: state_d = ST_RUN;
    endcase
    if (state_q == ST_RUN && waitReq) begin
      fromStby_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= ST_RUN;
      cnt_q      <= '0;
      lpSel_q    <= 1'b0;
      fromStby_q <= 1'b0;
      wkupPrev_q <= 1'b1;
    end else if (clkEn) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      lpSel_q    <= lpSel_d;
      fromStby_q <= fromStby_d;
      wkupPrev_q <= wkupPrev_d;
    end
  end

  // Crystal and PLL stay off through the wake states and come back on in ST_RUN and ST_SLEEP
  logic inDeep;
  logic inStby;
  logic clkOff;
  logic oscOff;

  assign inDeep = state_q == ST_DEEP;
  assign inStby = state_q == ST_STANDBY;
  assign clkOff = inDeep || inStby || state_q == ST_STBY_WAKE || state_q == ST_DEEP_WAKE;
  assign oscOff = inDeep || inStby;

  always_comb begin
    coreClkEn                 = !(clkOff || state_q == ST_SLEEP);
    periphClkEn               = !clkOff;
    coreDomainClkEn           = !clkOff;
    internal_rc_osc_fast_en   = !oscOff;
    high_speed_crystal_osc_en = !oscOff && state_q != ST_DEEP_WAKE
                                && state_q != ST_STBY_WAKE && state_q != ST_STBY_RESET;
    pllEn                     = high_speed_crystal_osc_en;
    internal_regulator_on     = !inStby;
    internal_regulator_lp     = inDeep && lpSel_q;
    retainState               = inDeep || state_q == ST_DEEP_WAKE;
    coreDomainPowered         = !inStby;
    coreDomainReset           = inStby || state_q == ST_STBY_WAKE
                                || state_q == ST_STBY_RESET;
    sysClkForceRc             = state_q == ST_DEEP_WAKE || state_q == ST_STBY_WAKE
                                || state_q == ST_STBY_RESET;
    sysClkSel                 = `SYSCLK_RC_FAST;
    wakeFromStandby           = fromStby_q;
    powerState                = state_q;
  end
endmodule : power_saving_mode_control

// [dv/power_saving_mode_control_properties.sv]
// Purpose: Port assertions for the power-mode controller
// Assumes: Bound to the controller top
// Notes: Entry, output and exit relations
`timescale 1ns/10ps
`include "power_mode_defs.svh"
module power_mode_checker
  import power_mode_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 clkEn,
  input wire logic                 waitReq,
  input wire logic [1:0]           targetMode,
  input wire logic                 regulator_low_power_select,
  input wire logic                 anyIrqOrEvent,
  input wire logic                 coreClkEn,
  input wire logic                 periphClkEn,
  input wire logic                 coreDomainClkEn,
  input wire logic                 internal_rc_osc_fast_en,
  input wire logic                 high_speed_crystal_osc_en,
  input wire logic                 pllEn,
  input wire logic                 internal_regulator_on,
  input wire logic                 internal_regulator_lp,
  input wire logic                 retainState,
  input wire logic                 coreDomainPowered,
  input wire logic                 coreDomainReset,
  input wire logic                 sysClkForceRc,
  input wire logic [`SYSCLK_W-1:0] sysClkSel,
  input wire pstate_t              powerState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    powerState == ST_RUN && clkEn && waitReq;
  endsequence
  property p_enter_sleep;   s_take ##0 targetMode == TGT_SLEEP |=> powerState == ST_SLEEP; endproperty
  property p_enter_deep;    s_take ##0 targetMode == TGT_DEEP |=> powerState == ST_DEEP; endproperty
  property p_enter_standby; s_take ##0 targetMode == TGT_STANDBY |=> powerState == ST_STANDBY; endproperty
  property p_mode_refused;  s_take ##0 targetMode == 2'h3 |=> powerState == ST_RUN; endproperty
  property p_sleep_gate;    powerState == ST_SLEEP |-> !coreClkEn && periphClkEn; endproperty
  property p_sleep_wake;    powerState == ST_SLEEP && clkEn && anyIrqOrEvent |=> powerState == ST_RUN; endproperty
  property p_deep_off;
    powerState == ST_DEEP |-> !coreDomainClkEn && !internal_rc_osc_fast_en && !high_speed_crystal_osc_en
      && !pllEn && retainState && coreDomainPowered;
  endproperty
  property p_deep_lp;
    $rose(powerState == ST_DEEP) |-> internal_regulator_on && internal_regulator_lp == $past(regulator_low_power_select);
  endproperty
  property p_deep_exit_rc;
    powerState == ST_DEEP_WAKE |-> sysClkForceRc && internal_rc_osc_fast_en && sysClkSel == `SYSCLK_RC_FAST;
  endproperty
  property p_stby_off;
    powerState == ST_STANDBY |-> !(coreDomainPowered || internal_regulator_on || internal_rc_osc_fast_en
      || high_speed_crystal_osc_en || pllEn);
  endproperty
  property p_stby_reset;    powerState == ST_STBY_RESET |-> coreDomainReset; endproperty
  a_enter_sleep:   assert property (p_enter_sleep) else $error("sleep entry wrong");
  a_enter_deep:    assert property (p_enter_deep) else $error("deep entry wrong");
  a_enter_standby: assert property (p_enter_standby) else $error("standby entry wrong");
  a_mode_refused:  assert property (p_mode_refused) else $error("mode 3 not ignored");
  a_sleep_gate:    assert property (p_sleep_gate) else $error("sleep clocks wrong");
  a_sleep_wake:    assert property (p_sleep_wake) else $error("sleep wake missed");
  a_deep_off:      assert property (p_deep_off) else $error("deep outputs wrong");
  a_deep_lp:       assert property (p_deep_lp) else $error("deep regulator wrong");
  a_deep_exit_rc:  assert property (p_deep_exit_rc) else $error("exit clock not RC");
  a_stby_off:      assert property (p_stby_off) else $error("standby outputs wrong");
  a_stby_reset:    assert property (p_stby_reset) else $error("core reset missing");
  c_sleep:   cover property (powerState == ST_SLEEP);
  c_deep:    cover property (powerState == ST_DEEP_WAKE);
  c_standby: cover property (powerState == ST_STBY_RESET);
endmodule : power_mode_checker

bind power_saving_mode_control power_mode_checker i_chk (.clk, .reset, .clkEn, .waitReq, .targetMode,
  .regulator_low_power_select, .anyIrqOrEvent, .coreClkEn, .periphClkEn, .coreDomainClkEn,
  .internal_rc_osc_fast_en, .high_speed_crystal_osc_en, .pllEn, .internal_regulator_on, .internal_regulator_lp,
  .retainState, .coreDomainPowered, .coreDomainReset, .sysClkForceRc, .sysClkSel, .powerState);

// [dv/cpu_request_model.sv]
// Purpose: CPU side issuing low-power requests
// Assumes: go pulse carries the wanted mode
// Notes: Mode is set a cycle before the wait
`timescale 1ns/10ps
module cpu_request_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic [1:0] mode,
  output logic            waitReq,
  output logic [1:0]      targetMode
);
  logic pending_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_q  <= 1'b0;
      waitReq    <= 1'b0;
      targetMode <= 2'h3;
    end else begin
      pending_q <= go;
      waitReq   <= pending_q;
      if (go) begin
        targetMode <= mode;
      end
    end
  end
endmodule : cpu_request_model

// [dv/power_saving_mode_control_test.sv]
// Purpose: Self-checking bench for the power-mode controller
// Assumes: CPU model issues the waits
// Notes: One task per scenario
`timescale 1ns/10ps
`include "power_mode_defs.svh"
module power_saving_mode_control_test
  import power_mode_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, clkEn = 1'b1, go = 1'b0, irq = 1'b0, lpSel = 1'b0;
  logic [1:0]  mode = 2'h3, targetMode, sysClkSel;
  logic [29:0] src = 30'h0;
  logic        waitReq, coreClkEn, periphClkEn, coreDomainClkEn, internal_rc_osc_fast_en, pllEn;
  logic        high_speed_crystal_osc_en, internal_regulator_on, internal_regulator_lp, retainState;
  logic        coreDomainPowered, coreDomainReset, sysClkForceRc, wakeFromStandby;
  pstate_t     powerState;
  int          errorCnt = 0, samplesChecked = 0;
  int          stIdx [7] = '{16, 17, 18, 20, 27, 28, 29};
  always #12.5 clk = ~clk;
  cpu_request_model i_cpu (.clk, .reset, .go, .mode, .waitReq, .targetMode);
  power_saving_mode_control i_dut (.clk, .clkEn, .reset, .waitReq, .targetMode,
    .regulator_low_power_select(lpSel), .anyIrqOrEvent(irq), .extLines(src[15:0]), .rtcAlarm(src[16]),
    .rtcTamper(src[17]), .rtcStamp(src[18]), .rtcWakeTimer(src[19]), .low_speed_crystal_osc_stuck(src[20]),
    .low_voltage_detector(src[21]), .analog_supply_detector(src[21]), .over_voltage_detector(src[21]),
    .under_voltage_detector(src[21]), .analog_comparator({8{src[22]}}), .low_power_timer(src[23]),
    .canWake(src[24]), .i2cWake(src[25]), .usartWake(src[26]), .free_running_watchdog_reset(src[27]),
    .wakeup_pin(src[28]), .external_reset_pin_n(~src[29]), .coreClkEn, .periphClkEn, .coreDomainClkEn,
    .internal_rc_osc_fast_en, .high_speed_crystal_osc_en, .pllEn, .internal_regulator_on, .internal_regulator_lp,
    .retainState, .coreDomainPowered, .coreDomainReset, .sysClkForceRc, .sysClkSel, .wakeFromStandby, .powerState);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic waitFor(input pstate_t s, input int lim);
    int n;
    n = 0;
    while (powerState !== s && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("powerState", s, powerState);
  endtask : waitFor
  task automatic enter(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : enter
  task automatic testSleep();
    enter(2'h3);
    chk("ignored", ST_RUN, powerState);
    enter(TGT_SLEEP);
    waitFor(ST_SLEEP, 2);
    chk("sleepClk", 8'h01, {coreClkEn, periphClkEn});
    @(posedge clk) clkEn <= 1'b0;
    irq <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("frozen", ST_SLEEP, powerState);
    @(posedge clk) clkEn <= 1'b1;
    @(posedge clk) irq <= 1'b0;
    #1;
    chk("sleepWake", ST_RUN, powerState);
    $display("testSleep done");
  endtask : testSleep
  task automatic testDeep();
    for (int i = 0; i < 27; i++) begin
      @(posedge clk) lpSel <= i[0];
      enter(TGT_DEEP);
      waitFor(ST_DEEP, 2);
      chk("deepOut", {5'h1, lpSel, 2'h3}, {coreDomainClkEn, internal_rc_osc_fast_en, high_speed_crystal_osc_en,
        pllEn, internal_regulator_on, internal_regulator_lp, retainState, coreDomainPowered});
      @(posedge clk) src <= 30'h1 << i;
      waitFor(ST_DEEP_WAKE, 6);
      chk("exitClk", 8'h0c, {sysClkForceRc, internal_rc_osc_fast_en, sysClkSel});
      @(posedge clk) src <= 30'h0;
      waitFor(ST_RUN, 90);
    end
    $display("testDeep done");
  endtask : testDeep
  task automatic testStandby();
    enter(TGT_STANDBY);
    @(posedge clk);
    irq <= 1'b1;
    src <= 30'h1080000;
    repeat (10) @(posedge clk);
    #1;
    chk("stbyHold", ST_STANDBY, powerState);
    @(posedge clk);
    irq <= 1'b0;
    src <= 30'h0;
    for (int k = 0; k < 7; k++) begin
      waitFor((k == 0) ? ST_STANDBY : ST_RUN, 2);
      if (k > 0) begin
        enter(TGT_STANDBY);
      end
      chk("stbyOut", 8'h0, {coreDomainClkEn, internal_rc_osc_fast_en, high_speed_crystal_osc_en, pllEn,
        internal_regulator_on, coreDomainPowered, wakeFromStandby});
      @(posedge clk) src <= 30'h1 << stIdx[k];
      repeat (4) @(posedge clk);
      src <= 30'h0;
      waitFor(ST_STBY_RESET, 100);
      chk("coreReset", 8'h1, coreDomainReset);
      waitFor(ST_RUN, 50);
      chk("wakeFlag", 8'h1, wakeFromStandby);
    end
    $display("testStandby done");
  endtask : testStandby
  task automatic completeRun();
    $display("Checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : completeRun
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    testSleep();
    testDeep();
    testStandby();
    completeRun();
  end
  initial begin
    #300000;
    errorCnt++;
    completeRun();
  end
endmodule : power_saving_mode_control_test
